// >>> src/lmb_scan_top.sv
// Purpose: mux-clock divider, fail-safe, digit scan, blink timing and segment decode
// Assumes: register writes arrive as one-cycle strobes from the serial front end
// Notes:   cs_rise is the synchronised chip-select rising edge, one cycle
module lmb_scan_top #(
  parameter int unsigned BLINK_FAST_HALF = lmb_pkg::BLINK_FAST_HALF,
  parameter int unsigned BLINK_SLOW_HALF = lmb_pkg::BLINK_SLOW_HALF
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       mux_clock_input,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       cs_rise,
  output logic      [7:0] digit_enable,
  output logic      [7:0] segment_out,
  output logic            blink_phase,
  output logic            failsafe_active
);
  logic       osc_s1_r, osc_s2_r, osc_s3_r, osc_lvl_r;
  logic       osc_edge, fs_fire, tick;
  logic [lmb_pkg::FS_W-1:0]    fs_cnt_r;
  logic [lmb_pkg::SLOT_W-1:0]  slot_cnt_r;
  logic [2:0] digit_r, digit_d_r;
  logic [lmb_pkg::BLINK_W-1:0] blink_cnt_r, half_sel;
  logic       phase_r, phase_due_r, sync_pend_r, sync_fire;
  logic       phase_d_r;  // phase aligned with the registered ram read
  logic       slot_end, scan_wrap, digit_valid_r, use_p1;
  logic [7:0] decode_sel_r, config_r, rd_p0, rd_p1, byte_sel, seg_nxt;
  logic [2:0] scan_limit_r;
  logic       wr_digit, we_p0, we_p1;

  // three-stage synchroniser; a level counts once the last two stages agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
      osc_s3_r  <= 1'b0;
      osc_lvl_r <= 1'b0;
    end else begin
      osc_s1_r <= mux_clock_input;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      if (osc_s2_r == osc_s3_r) osc_lvl_r <= osc_s3_r;
    end
  end
  assign osc_edge = (osc_s2_r == osc_s3_r) && osc_s3_r && !osc_lvl_r;

  // fail-safe watches every mux clock source the same way, so a stopped pin
  // still advances the scan and no digit is left on continuously
  assign fs_fire = !osc_edge && (fs_cnt_r == lmb_pkg::FS_LAST);
  assign tick    = osc_edge || fs_fire;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fs_cnt_r        <= '0;
      failsafe_active <= 1'b0;
    end else begin
      fs_cnt_r <= tick ? '0 : fs_cnt_r + 1'b1;
      if (osc_edge) failsafe_active <= 1'b0;
      else if (fs_fire) failsafe_active <= 1'b1;
    end
  end

  // register writes; sync arms on the config write and fires on cs_rise
  assign wr_digit = wr_en && (wr_addr[4:3] == 2'b00);
  assign we_p0 = wr_digit && (wr_addr[7:5] == lmb_pkg::DIGIT_P0
                          || wr_addr[7:5] == lmb_pkg::DIGIT_BOTH);
  assign we_p1 = wr_digit && (wr_addr[7:5] == lmb_pkg::DIGIT_P1
                          || wr_addr[7:5] == lmb_pkg::DIGIT_BOTH);
  assign sync_fire = cs_rise && sync_pend_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      decode_sel_r <= lmb_pkg::DECODE_RST;
      scan_limit_r <= lmb_pkg::LIMIT_RST;
      config_r     <= lmb_pkg::CONFIG_RST;
      sync_pend_r  <= 1'b0;
    end else begin
      if (wr_en && wr_addr == lmb_pkg::ADDR_DECODE_SEL) decode_sel_r <= wr_data;
      if (wr_en && wr_addr == lmb_pkg::ADDR_SCAN_LIMIT) scan_limit_r <= wr_data[2:0];
      if (wr_en && wr_addr == lmb_pkg::ADDR_CONFIG) begin
        config_r    <= wr_data;
        sync_pend_r <= wr_data[lmb_pkg::CFG_SYNC];
      end else if (cs_rise) begin
        sync_pend_r <= 1'b0;
      end
    end
  end

  lmb_digit_ram u_ram (
    .clk      (clk),
    .resetn   (resetn),
    .clear    (cs_rise && config_r[lmb_pkg::CFG_CLEAR]),
    .we_p0    (we_p0),
    .we_p1    (we_p1),
    .waddr    (wr_addr[2:0]),
    .wdata    (wr_data),
    .raddr    (digit_r),
    .rdata_p0 (rd_p0),
    .rdata_p1 (rd_p1)
  );

  // digit slots: equal tick count per digit, ascending, wrap at the limit
  assign slot_end  = tick && (slot_cnt_r == lmb_pkg::SLOT_LAST);
  assign scan_wrap = slot_end && (digit_r >= scan_limit_r);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slot_cnt_r <= '0;
      digit_r    <= 3'h0;
    end else if (sync_fire) begin
      slot_cnt_r <= '0;
      digit_r    <= 3'h0;
    end else if (tick) begin
      slot_cnt_r <= slot_end ? '0 : slot_cnt_r + 1'b1;
      if (slot_end) digit_r <= scan_wrap ? 3'h0 : digit_r + 3'h1;
    end
  end

  // blink divider; a finished half period waits for the scan boundary
  assign half_sel = config_r[lmb_pkg::CFG_RATE] ? lmb_pkg::BLINK_W'(BLINK_FAST_HALF - 1)
                                                : lmb_pkg::BLINK_W'(BLINK_SLOW_HALF - 1);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blink_cnt_r <= '0;
      phase_due_r <= 1'b0;
      phase_r     <= 1'b0;
    end else if (sync_fire) begin
      blink_cnt_r <= '0;
      phase_due_r <= 1'b0;
      phase_r     <= 1'b0;
    end else begin
      if (tick) blink_cnt_r <= (blink_cnt_r >= half_sel) ? '0 : blink_cnt_r + 1'b1;
      if (scan_wrap) begin
        phase_r     <= phase_r ^ (phase_due_r || (tick && blink_cnt_r >= half_sel));
        phase_due_r <= 1'b0;
      end else if (tick && blink_cnt_r >= half_sel) begin
        phase_due_r <= 1'b1;
      end
    end
  end

  // output stage, aligned with the registered ram read; the delayed phase keeps
  // the last digit of a pass from showing one cycle of the next plane
  assign use_p1   = config_r[lmb_pkg::CFG_BLINK] && phase_d_r;
  assign byte_sel = use_p1 ? rd_p1 : rd_p0;
  always_comb begin
    if (decode_sel_r[digit_d_r])
      seg_nxt = {byte_sel[lmb_pkg::DP_BIT], lmb_pkg::lmb_hex_font(byte_sel[3:0])};
    else
      seg_nxt = byte_sel;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      digit_d_r     <= 3'h0;
      phase_d_r     <= 1'b0;
      digit_valid_r <= 1'b0;
      digit_enable  <= 8'h00;
      segment_out   <= 8'h00;
      blink_phase   <= 1'b0;
    end else begin
      digit_d_r     <= digit_r;
      phase_d_r     <= phase_r;
      digit_valid_r <= 1'b1;
      blink_phase   <= phase_d_r;
      if (digit_valid_r && config_r[lmb_pkg::CFG_RUN]) begin
        digit_enable <= 8'h01 << digit_d_r;
        segment_out  <= seg_nxt;
      end else begin
        digit_enable <= 8'h00;
        segment_out  <= 8'h00;
      end
    end
  end

  // assertion helpers
  logic [lmb_pkg::FS_W:0] since_tick_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) since_tick_r <= '0;
    else since_tick_r <= tick ? '0 : since_tick_r + 1'b1;
  end

  sequence s_sync_armed;
    wr_en && wr_addr == lmb_pkg::ADDR_CONFIG && wr_data[lmb_pkg::CFG_SYNC];
  endsequence
  sequence s_cs_end;
    cs_rise && !wr_en;
  endsequence
  sequence s_idle;
    !cs_rise && !wr_en;
  endsequence

  AST_SLOT_STEP: assert property (@(posedge clk) disable iff (!resetn)
    slot_end && !scan_wrap && !sync_fire |=> digit_r == $past(digit_r) + 3'h1)
    else $error("digit did not advance at slot end");
  AST_WRAP_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    scan_wrap && !sync_fire |=> digit_r == 3'h0 && slot_cnt_r == '0)
    else $error("scan did not wrap to digit zero");
  AST_FAILSAFE_GAP: assert property (@(posedge clk) disable iff (!resetn)
    since_tick_r <= (lmb_pkg::FS_W + 1)'(lmb_pkg::FAILSAFE_CYC - 1))
    else $error("mux tick gap exceeded fail-safe limit");
  AST_SYNC_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
    s_sync_armed ##1 s_idle ##1 s_cs_end |=> digit_r == 3'h0 && slot_cnt_r == '0
                                  && blink_cnt_r == '0 && !phase_r)
    else $error("sync write did not clear dividers");
  AST_SYNC_WAITS_CS: assert property (@(posedge clk) disable iff (!resetn)
    s_sync_armed ##1 s_idle |=> sync_pend_r)
    else $error("sync cleared before chip-select rise");
  AST_PHASE_BOUNDARY: assert property (@(posedge clk) disable iff (!resetn)
    $changed(phase_r) |-> $past(scan_wrap) || $past(sync_fire))
    else $error("blink phase moved inside a scan pass");
  AST_PLANE_SEL: assert property (@(posedge clk) disable iff (!resetn)
    digit_valid_r && config_r[lmb_pkg::CFG_RUN] && !config_r[lmb_pkg::CFG_BLINK]
      && !decode_sel_r[digit_d_r] |=> segment_out == $past(rd_p0))
    else $error("second plane shown with blink off");
  AST_RATE_BOUND: assert property (@(posedge clk) disable iff (!resetn)
    blink_cnt_r <= lmb_pkg::BLINK_W'(BLINK_SLOW_HALF - 1))
    else $error("blink divider ran past slow half period");
  AST_DP_DECODE: assert property (@(posedge clk) disable iff (!resetn)
    digit_valid_r && config_r[lmb_pkg::CFG_RUN] && decode_sel_r[digit_d_r]
      |=> segment_out[lmb_pkg::DP_BIT] == $past(byte_sel[lmb_pkg::DP_BIT]))
    else $error("decimal point not taken from D7");
  AST_ONE_DIGIT: assert property (@(posedge clk) disable iff (!resetn)
    $onehot0(digit_enable))
    else $error("more than one digit enabled");
endmodule

// >>> src/lmb_pkg.sv
// Purpose: constants, register map and font for the scan, blink and decode block
// Assumes: 125 MHz system clock, mux clock pin sampled as an asynchronous level
// Notes:   tick counts in mux-clock ticks, fail-safe count in system clocks
// Function
// - full refresh is the mux clock divided by 4000 (five digits) or 6400 (eight).
// - every digit gets an equal slot; 4 MHz mux clock gives 200 us per digit.
// - too slow a mux clock gets extra ticks, keeping about 75.5 kHz effective.
// - slow-clock detection works for internal and external mux clock alike.
// - at 4 MHz the slow blink is 0.5 Hz and the fast blink 1 Hz.
// - config write with sync bit clears the divider chain and restarts scanning.
// - that clearing happens on the chip-select rising edge ending the write.
// - decode-select register, one bit per digit, 1 selects hex decode.
// - decoded digit: D7 lights decimal point, D3-D0 pick the hex font.
// - raw digit: D7 drives decimal point, D6..D0 drive segments a..g.
// - blink on scans first plane then second plane; blink off scans first only.
// - one config bit picks fast or slow blink for the whole display.
// - low three bits of scan-limit register give the highest digit scanned.
package lmb_pkg;
  localparam int unsigned CLK_HZ       = 125000000;
  localparam int unsigned MUX_REF_HZ   = 4000000;   // reference mux clock rate
  localparam int unsigned SCAN_DIV_5   = 4000;
  localparam int unsigned SCAN_DIV_8   = 6400;
  localparam int unsigned DIGITS_5     = 5;
  localparam int unsigned DIGITS_8     = 8;
  localparam int unsigned SLOT_US      = 200;
  localparam int unsigned SLOT_TICKS   = SCAN_DIV_8 / DIGITS_8;  // equals SCAN_DIV_5 / DIGITS_5
  localparam int unsigned FAILSAFE_HZ  = 75500;
  // longest gap between ticks, rounded down
  localparam int unsigned FAILSAFE_CYC = CLK_HZ / FAILSAFE_HZ;
  localparam int unsigned BLINK_FAST_MS = 1000;    // 1 Hz period
  localparam int unsigned BLINK_SLOW_MS = 2000;    // 0.5 Hz period
  localparam int unsigned BLINK_FAST_HALF = (MUX_REF_HZ / 1000) * BLINK_FAST_MS / 2;
  localparam int unsigned BLINK_SLOW_HALF = (MUX_REF_HZ / 1000) * BLINK_SLOW_MS / 2;

  localparam int SLOT_W  = 10;
  localparam int BLINK_W = 23;
  localparam int FS_W    = 11;
  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_TICKS - 1);
  localparam logic [FS_W-1:0]   FS_LAST   = FS_W'(FAILSAFE_CYC - 1);

  // register addresses
  localparam logic [7:0] ADDR_DECODE_SEL = 8'h01;
  localparam logic [7:0] ADDR_SCAN_LIMIT = 8'h03;
  localparam logic [7:0] ADDR_CONFIG     = 8'h04;
  localparam logic [2:0] DIGIT_P0        = 3'h1;  // addr[7:5] for first plane
  localparam logic [2:0] DIGIT_P1        = 3'h2;  // addr[7:5] for second plane
  localparam logic [2:0] DIGIT_BOTH      = 3'h3;  // addr[7:5] for both planes

  // configuration bits
  localparam int CFG_RUN   = 0;
  localparam int CFG_RATE  = 2;   // 1 selects fast blink
  localparam int CFG_BLINK = 3;
  localparam int CFG_SYNC  = 4;
  localparam int CFG_CLEAR = 5;

  localparam logic [7:0] DECODE_RST = 8'h00;
  localparam logic [2:0] LIMIT_RST  = 3'h7;
  localparam logic [7:0] CONFIG_RST = 8'h00;   // blanked after reset
  localparam int DP_BIT = 7;

  // hex font, segments {a,b,c,d,e,f,g}
  function automatic logic [6:0] lmb_hex_font(input logic [3:0] v);
    logic [6:0] f;
    f = 7'h00;
    unique case (v)
      4'h0: f = 7'h7e;
      4'h1: f = 7'h30;
      4'h2: f = 7'h6d;
      4'h3: f = 7'h79;
      4'h4: f = 7'h33;
      4'h5: f = 7'h5b;
      4'h6: f = 7'h5f;
      4'h7: f = 7'h70;
      4'h8: f = 7'h7f;
      4'h9: f = 7'h7b;
      4'ha: f = 7'h77;
      4'hb: f = 7'h1f;
      4'hc: f = 7'h4e;
      4'hd: f = 7'h3f;
      4'he: f = 7'h4f;
      4'hf: f = 7'h47;
    endcase
    return f;
  endfunction
endpackage

// >>> src/lmb_digit_ram.sv
// Purpose: two-plane digit data store, eight bytes per plane
// Assumes: one write per cycle, read data registered
// Notes:   clear wipes both planes in one cycle; it wins over a write
module lmb_digit_ram (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       clear,
  input  wire logic       we_p0,
  input  wire logic       we_p1,
  input  wire logic [2:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [2:0] raddr,
  output logic      [7:0] rdata_p0,
  output logic      [7:0] rdata_p1
);
  logic [7:0] plane0_r [8];
  logic [7:0] plane1_r [8];

  // storage; both planes read together so blink can pick either
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        plane0_r[i] <= 8'h00;
        plane1_r[i] <= 8'h00;
      end
    end else if (clear) begin
      for (int i = 0; i < 8; i++) begin
        plane0_r[i] <= 8'h00;
        plane1_r[i] <= 8'h00;
      end
    end else begin
      if (we_p0) plane0_r[waddr] <= wdata;
      if (we_p1) plane1_r[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_p0 <= 8'h00;
      rdata_p1 <= 8'h00;
    end else begin
      rdata_p0 <= plane0_r[raddr];
      rdata_p1 <= plane1_r[raddr];
    end
  end
endmodule

// >>> test/lmb_mux_clk_src.sv
// Purpose: external mux clock source driven onto the mux clock pin
// Assumes: one shared source may feed several drivers
// Notes:   a stopped source holds its last level, as a dead oscillator does
module lmb_mux_clk_src #(
  parameter real HALF_NS = 62.5
) (
  input  wire logic run,
  output logic      mux_clock_input
);
  timeunit 1ns;
  timeprecision 100ps;
  // 8 MHz square wave, the top of the allowed range keeps the run short
  initial begin
    mux_clock_input = 1'b0;
    forever begin
      #(HALF_NS);
      if (run) begin
        mux_clock_input = ~mux_clock_input;
      end
    end
  end
endmodule

// >>> test/led_mux_blink_decode_tb.sv
// Purpose: self-checking bench for scan, blink, fail-safe and decode
// Assumes: 125 MHz clk, 8 MHz mux clock, so one tick is 15.625 clk
// Notes:   blink halves shortened to 4 and 900 ticks; slot stays 800 ticks
module led_mux_blink_decode_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SLOT_CLK = 12500;  // 800 ticks at 125 ns
  localparam logic [6:0] FONT [16] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f,
    7'h70, 7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3f, 7'h4f, 7'h47};
  logic       clk;
  logic       resetn;
  logic       mux_run;
  logic       mux_clock_input;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       cs_rise;
  logic [7:0] digit_enable;
  logic [7:0] segment_out;
  logic       blink_phase;
  logic       failsafe_active;
  int         num_errors;
  int         checks_done;
  int         n;

  lmb_mux_clk_src i_src (.run(mux_run), .mux_clock_input(mux_clock_input));
  lmb_scan_top #(.BLINK_FAST_HALF(4), .BLINK_SLOW_HALF(900)) i_dut (
    .clk(clk), .resetn(resetn), .mux_clock_input(mux_clock_input), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .cs_rise(cs_rise), .digit_enable(digit_enable),
    .segment_out(segment_out), .blink_phase(blink_phase), .failsafe_active(failsafe_active));

  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one-cycle write strobe, then a gap edge so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic cs_pulse;
    @(posedge clk);
    cs_rise <= 1'b1;
    @(posedge clk);
    cs_rise <= 1'b0;
  endtask

  // counts clk edges until the watched output moves; bounded
  task automatic wait_chg(input bit phase_sel, output int cnt);
    logic [7:0] s0;
    s0 = phase_sel ? {7'h00, blink_phase} : digit_enable;
    cnt = 0;
    while ((phase_sel ? {7'h00, blink_phase} : digit_enable) === s0 && cnt < 40000) begin
      @(posedge clk);
      cnt++;
    end
  endtask

  function automatic logic [15:0] near(input int got, input int exp);
    return {15'h0000, (got >= exp - 48 && got <= exp + 48)};
  endfunction

  task automatic t_reset;
    wr(8'h20, 8'hff);
    repeat (8) @(posedge clk);
    check({8'h00, digit_enable}, 16'h0000);
    check({8'h00, segment_out}, 16'h0000);
  endtask

  task automatic t_decode;
    wr(8'h03, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h04, 8'h01);
    wr(8'h20, 8'ha5);
    repeat (8) @(posedge clk);
    check({8'h00, digit_enable}, 16'h0001);
    check({8'h00, segment_out}, 16'h00a5);
    wr(8'h01, 8'hff);
    // high nibble garbage must not reach the font lookup
    for (int v = 0; v < 16; v++) begin
      wr(8'h20, {v[0], 3'h5, 4'(v)});
      repeat (6) @(posedge clk);
      check({8'h00, segment_out}, {8'h00, v[0], FONT[v]});
    end
    wr(8'h01, 8'hfe);
    wr(8'h20, 8'h0b);
    repeat (6) @(posedge clk);
    check({8'h00, segment_out}, 16'h000b);
  endtask

  task automatic t_scan;
    wr(8'h03, 8'h01);
    // let the scan reach digit 1 first, so the sync has something to undo
    wait_chg(1'b0, n);
    check({8'h00, digit_enable}, 16'h0002);
    wr(8'h04, 8'h11);
    cs_pulse();
    repeat (4) @(posedge clk);
    check({8'h00, digit_enable}, 16'h0001);
    wait_chg(1'b0, n);
    check({8'h00, digit_enable}, 16'h0002);
    check(near(n, SLOT_CLK - 4), 16'h0001);
    wait_chg(1'b0, n);
    check({8'h00, digit_enable}, 16'h0001);
    check(near(n, SLOT_CLK), 16'h0001);
  endtask

  task automatic t_blink(input logic [7:0] cfg, input int passes);
    wr(8'h03, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h20, 8'h41);
    wr(8'h40, 8'h22);
    wr(8'h04, cfg);
    cs_pulse();
    repeat (4) @(posedge clk);
    check({15'h0000, blink_phase}, 16'h0000);
    check({8'h00, segment_out}, 16'h0041);
    wait_chg(1'b1, n);
    check(near(n, passes * SLOT_CLK - 4), 16'h0001);
    repeat (4) @(posedge clk);
    check({8'h00, segment_out}, 16'h0022);
  endtask

  task automatic t_failsafe;
    @(posedge mux_clock_input);
    mux_run <= 1'b0;
    n = 0;
    while (failsafe_active !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    check({15'h0000, (n >= 1600 && n <= 1720)}, 16'h0001);
    mux_run <= 1'b1;
    n = 0;
    while (failsafe_active !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check({15'h0000, failsafe_active}, 16'h0000);
  endtask

  // hang guard, some margin above the expected run of about 77000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    num_errors = 0;
    checks_done = 0;
    resetn = 1'b0;
    mux_run = 1'b1;
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    cs_rise = 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_decode();
    t_scan();
    t_blink(8'h1d, 1);
    t_blink(8'h19, 2);
    t_failsafe();
    tally_and_finish();
  end
endmodule
